// ### pkg/ciru_regs.vh
`ifndef CIRU_REGS_VH
`define CIRU_REGS_VH

// Register offsets on the plain register port.
`define CIRU_OFS_TRAP_CTRL   8'h00
`define CIRU_OFS_VEC_BASE    8'h04
`define CIRU_OFS_VEC_LOW     8'h08
`define CIRU_OFS_DMA_CTRL    8'h0c
`define CIRU_OFS_STATUS      8'h10

// Trap/control register fields.
`define CIRU_TC_TRAP_BIT     7
`define CIRU_TC_EN0_BIT      0
`define CIRU_TC_EN1_BIT      1
`define CIRU_TC_EN2_BIT      2
`define CIRU_TC_RESET        8'h01

// Vector base and vector-low register.
`define CIRU_VEC_BASE_RESET  8'h00
`define CIRU_VEC_LOW_RESET   3'h0

// DMA control register field.
`define CIRU_DMA_ME_BIT      0
`define CIRU_DMA_RESET       8'h00

// Fixed restart addresses.
`define CIRU_NMI_ADDR        16'h0066
`define CIRU_MODE1_ADDR      16'h0038

// Level-0 response modes.
`define CIRU_MODE0           2'h0
`define CIRU_MODE1           2'h1
`define CIRU_MODE2           2'h2

// Acknowledge cycle: T1, T2, two wait states, T3.
`define CIRU_ACK_T2          3'h1
`define CIRU_ACK_TW_LAST     3'h3
`define CIRU_ACK_T3          3'h4

// Number of vectored sources (level-1, level-2, seven internal).
`define CIRU_NUM_VEC         9
`define CIRU_NUM_INTERNAL    7

`endif

// ### core/ciru_vec_sel.v
`timescale 1ns/1ns
`default_nettype none

// Fixed priority picker: bit 0 is the highest priority source. The low
// vector code of source k is k shifted left by one, which gives the five
// bit codes 00000, 00010 ... 10000 for nine sources.
module ciru_vec_sel
#(
  parameter N = 9
)
(
  input  wire [N-1:0] req,
  output reg          any,
  output reg  [4:0]   code
);

  integer k;

  always @*
  begin
    any  = 1'b0;
    code = 5'h00;
    for (k = N - 1; k >= 0; k = k - 1)
    begin
      if (req[k])
      begin
        any  = 1'b1;
        code = {k[3:0], 1'b0};
      end
    end
  end

endmodule

`default_nettype wire

// ### core/ciru_top.v
`timescale 1ns/1ns
`default_nettype none

`include "ciru_regs.vh"

// How it works
// - Accepting a non-maskable request first clears the DMA master enable bit.
// - Non-maskable: push PC, save global flag, clear it, restart at 0066H.
// - Return-from-nonmaskable copies the saved flag back to the global flag.
// - Falling edge of the non-maskable pin is latched until sampled, unmasked.
// - Latched non-maskable sampled at last-cycle sample point; ack at cycle end.
// - Non-maskable requests are accepted while DMA is transferring.
// - Level-0 accepted when sampled low at the last-cycle sample point.
// - Level-0 ignored if global flag or level-0 enable is zero.
// - Priority: non-maskable, then level-0, then level-1, level-2, internal.
// - Mode set instructions pick modes 0/1/2; reset gives mode 0, enable0 set.
// - Mode 0 fetches an instruction from the data bus at T3, no PC push.
// - Undefined instruction fetched in mode 0 acknowledge raises the trap.
// - Mode 1 pushes PC, clears both flags, restarts at 0038H.
// - Mode 2 reads vector byte at T3, pushes PC, reads address low first.
// - Mode 2 table lies on a 256-byte boundary given by vector base.
// - External vector fetch drives both strobes low and adds two waits.
// - Reset loads the vector base register with 00H.
// - Vectored sources: top three bits from vector-low, low five fixed.
// - Fixed codes 00000 to 10000 in steps of two, by priority.
// - Level-1/2 blocked by global flag and by their own enable bits.
// - Reset clears the global flag and the level-1/2 enables.
// - Internal requests need the global flag and their own enable.
// - Level-1/2 accepted when sampled low at the last-cycle sample point.
// - Enable-all sets both flags; mask-all clears both.
// - Reset clears the three upper bits of the vector-low register.
// - Trap/control bits 2..0 gate level-2, level-1, level-0 inputs.
module ciru_top
(
  input  wire        clk,
  input  wire        nrst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        nmi_n,
  input  wire        level0_request_n,
  input  wire        level1_request_n,
  input  wire        level2_request_n,
  input  wire [6:0]  int_req,
  input  wire [6:0]  int_enable,
  input  wire        last_cycle_sample,
  input  wire        mcycle_end,
  input  wire        exec_enable_all,
  input  wire        exec_mask_all,
  input  wire        exec_return_from_nonmaskable,
  input  wire        exec_mode_set,
  input  wire [1:0]  exec_mode,
  input  wire [7:0]  data_in,
  input  wire        insn_undefined,
  input  wire [7:0]  mem_rdata,
  input  wire        mem_valid,
  output reg         ack_active,
  output reg         opcode_fetch_strobe_n,
  output reg         io_request_strobe_n,
  output reg         wait_state,
  output reg         push_pc,
  output reg         restart_valid,
  output reg  [15:0] restart_addr,
  output reg         vec_read,
  output reg  [15:0] vec_addr,
  output reg         insn_valid,
  output reg  [7:0]  insn_byte,
  output reg         trap_req,
  output reg         global_mask_flag,
  output reg         saved_mask_flag,
  output reg         dma_master_enable
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_ARMED = 3'h1;
  localparam ST_ACK   = 3'h2;
  localparam ST_CHECK = 3'h3;
  localparam ST_PUSH  = 3'h4;
  localparam ST_RD_LO = 3'h5;
  localparam ST_RD_HI = 3'h6;

  localparam [7:0] TC_RESET = `CIRU_TC_RESET;

  localparam K_NMI = 2'h0;
  localparam K_L0  = 2'h1;
  localparam K_VEC = 2'h2;

  reg  [2:0]  state;
  reg  [1:0]  kind;
  reg  [1:0]  mode;
  reg  [2:0]  ack_cnt;
  reg  [7:0]  vec_lo;
  reg  [7:0]  tbl_lo;
  reg         nmi_prev;
  reg         nmi_pend;
  reg         level0_enable;
  reg         level1_enable;
  reg         level2_enable;
  reg         trap_flag;
  reg  [7:0]  vector_base;
  reg  [2:0]  vector_low_register;

  wire        vec_any;
  wire [4:0]  vec_code;
  wire [8:0]  vec_req;
  wire        take_nmi;
  wire        take_l0;
  wire        take_vec;
  wire        accept;
  wire        wr_tc;
  wire        wr_dma;

  ////////////////////////////////////////////////////////////////////////
  // Request qualification and priority.

  assign vec_req = {int_req & int_enable,
                    ~level2_request_n & level2_enable,
                    ~level1_request_n & level1_enable}
                   & {9{global_mask_flag}};

  ciru_vec_sel
  #(
    .N (`CIRU_NUM_VEC)
  )
  u_vec_sel
  (
    .req  (vec_req),
    .any  (vec_any),
    .code (vec_code)
  );

  // sample only at last cycle
  // The sample pulse is only raised by the sequencer in an instruction's
  // last machine cycle, so nothing is taken mid-instruction.
  assign take_nmi = last_cycle_sample & (state == ST_IDLE) & nmi_pend;
  assign take_l0  = last_cycle_sample & (state == ST_IDLE) & ~nmi_pend
                    & ~level0_request_n & level0_enable & global_mask_flag;
  assign take_vec = last_cycle_sample & (state == ST_IDLE) & ~nmi_pend
                    & ~take_l0 & vec_any;
  assign accept   = take_nmi | take_l0 | take_vec;

  ////////////////////////////////////////////////////////////////////////
  // Non-maskable edge latch.

  // no DMA dependency
  // An edge in the sampling cycle itself stays pending for the next sample
  // rather than being dropped by the clear.
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      nmi_prev <= 1'b1;
      nmi_pend <= 1'b0;
    end
    else
    begin
      nmi_prev <= nmi_n;
      if (nmi_prev & ~nmi_n)
        nmi_pend <= 1'b1;
      else if (take_nmi)
        nmi_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port.

  assign wr_tc  = reg_wr & (reg_addr == `CIRU_OFS_TRAP_CTRL);
  assign wr_dma = reg_wr & (reg_addr == `CIRU_OFS_DMA_CTRL);

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      level0_enable       <= TC_RESET[`CIRU_TC_EN0_BIT];
      level1_enable       <= 1'b0;
      level2_enable       <= 1'b0;
      vector_base         <= `CIRU_VEC_BASE_RESET;
      vector_low_register <= `CIRU_VEC_LOW_RESET;
      dma_master_enable   <= 1'b0;
      trap_flag           <= 1'b0;
      reg_rdata           <= 8'h00;
    end
    else
    begin
      if (wr_tc)
      begin
        level0_enable <= reg_wdata[`CIRU_TC_EN0_BIT];
        level1_enable <= reg_wdata[`CIRU_TC_EN1_BIT];
        level2_enable <= reg_wdata[`CIRU_TC_EN2_BIT];
      end
      if (reg_wr && reg_addr == `CIRU_OFS_VEC_BASE)
        vector_base <= reg_wdata;
      if (reg_wr && reg_addr == `CIRU_OFS_VEC_LOW)
        vector_low_register <= reg_wdata[7:5];
      // suspend DMA on NMI
      // The hardware clear beats a software write in the same cycle.
      if (take_nmi)
        dma_master_enable <= 1'b0;
      else if (wr_dma)
        dma_master_enable <= reg_wdata[`CIRU_DMA_ME_BIT];
      // trap flag set
      // The trap flag can only be cleared by software; a new trap wins.
      if (state == ST_CHECK && insn_undefined)
        trap_flag <= 1'b1;
      else if (wr_tc && !reg_wdata[`CIRU_TC_TRAP_BIT])
        trap_flag <= 1'b0;
      if (reg_rd)
      begin
        case (reg_addr)
          `CIRU_OFS_TRAP_CTRL:
            reg_rdata <= {trap_flag, 4'h0, level2_enable,
                          level1_enable, level0_enable};
          `CIRU_OFS_VEC_BASE:
            reg_rdata <= vector_base;
          `CIRU_OFS_VEC_LOW:
            reg_rdata <= {vector_low_register, 5'h00};
          `CIRU_OFS_DMA_CTRL:
            reg_rdata <= {7'h00, dma_master_enable};
          `CIRU_OFS_STATUS:
            reg_rdata <= {global_mask_flag, saved_mask_flag, mode,
                          nmi_pend, state};
          default:
            reg_rdata <= 8'h00;
        endcase
      end
      else
        reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mask flags and response mode.

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      global_mask_flag <= 1'b0;
      saved_mask_flag  <= 1'b0;
      mode             <= `CIRU_MODE0;
    end
    else
    begin
      if (exec_mode_set && exec_mode != 2'h3)
        mode <= exec_mode;
      if (take_nmi)
      begin
        saved_mask_flag  <= global_mask_flag;
        global_mask_flag <= 1'b0;
      end
      else if (take_l0 || take_vec)
      begin
        global_mask_flag <= 1'b0;
        saved_mask_flag  <= 1'b0;
      end
      else if (exec_return_from_nonmaskable)
        global_mask_flag <= saved_mask_flag;
      else if (exec_enable_all)
      begin
        global_mask_flag <= 1'b1;
        saved_mask_flag  <= 1'b1;
      end
      else if (exec_mask_all)
      begin
        global_mask_flag <= 1'b0;
        saved_mask_flag  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge sequencer.

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      state                 <= ST_IDLE;
      kind                  <= K_NMI;
      ack_cnt               <= 3'h0;
      vec_lo                <= 8'h00;
      tbl_lo                <= 8'h00;
      ack_active            <= 1'b0;
      opcode_fetch_strobe_n <= 1'b1;
      io_request_strobe_n   <= 1'b1;
      wait_state            <= 1'b0;
      push_pc               <= 1'b0;
      restart_valid         <= 1'b0;
      restart_addr          <= 16'h0000;
      vec_read              <= 1'b0;
      vec_addr              <= 16'h0000;
      insn_valid            <= 1'b0;
      insn_byte             <= 8'h00;
      trap_req              <= 1'b0;
    end
    else
    begin
      push_pc       <= 1'b0;
      restart_valid <= 1'b0;
      vec_read      <= 1'b0;
      insn_valid    <= 1'b0;
      trap_req      <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (accept)
          begin
            state      <= ST_ARMED;
            ack_active <= 1'b1;
            kind       <= take_nmi ? K_NMI : (take_l0 ? K_L0 : K_VEC);
            vec_lo     <= {vector_low_register, vec_code};
          end
        end
        ST_ARMED:
        begin
          if (mcycle_end)
          begin
            if (kind == K_L0 && mode != `CIRU_MODE1)
            begin
              state                 <= ST_ACK;
              ack_cnt               <= 3'h0;
              opcode_fetch_strobe_n <= 1'b0;
              io_request_strobe_n   <= 1'b0;
            end
            else
              state <= ST_PUSH;
          end
        end
        ST_ACK:
        begin
          ack_cnt    <= ack_cnt + 3'h1;
          wait_state <= (ack_cnt >= `CIRU_ACK_T2)
                        && (ack_cnt < `CIRU_ACK_TW_LAST);
          if (ack_cnt == `CIRU_ACK_T3)
          begin
            opcode_fetch_strobe_n <= 1'b1;
            io_request_strobe_n   <= 1'b1;
            if (mode == `CIRU_MODE0)
            begin
              insn_valid <= 1'b1;
              insn_byte  <= data_in;
              state      <= ST_CHECK;
            end
            else
            begin
              vec_lo <= data_in;
              state  <= ST_PUSH;
            end
          end
        end
        ST_CHECK:
        begin
          trap_req   <= insn_undefined;
          ack_active <= 1'b0;
          state      <= ST_IDLE;
        end
        ST_PUSH:
        begin
          push_pc <= 1'b1;
          if (kind == K_NMI)
          begin
            restart_valid <= 1'b1;
            restart_addr  <= `CIRU_NMI_ADDR;
            ack_active    <= 1'b0;
            state         <= ST_IDLE;
          end
          else if (kind == K_L0 && mode == `CIRU_MODE1)
          begin
            restart_valid <= 1'b1;
            restart_addr  <= `CIRU_MODE1_ADDR;
            ack_active    <= 1'b0;
            state         <= ST_IDLE;
          end
          else
          begin
            vec_read <= 1'b1;
            vec_addr <= {vector_base, vec_lo};
            state    <= ST_RD_LO;
          end
        end
        ST_RD_LO:
        begin
          if (mem_valid)
          begin
            tbl_lo   <= mem_rdata;
            vec_read <= 1'b1;
            vec_addr <= vec_addr + 16'h0001;
            state    <= ST_RD_HI;
          end
        end
        ST_RD_HI:
        begin
          if (mem_valid)
          begin
            restart_valid <= 1'b1;
            restart_addr  <= {mem_rdata, tbl_lo};
            ack_active    <= 1'b0;
            state         <= ST_IDLE;
          end
        end
        default:
        begin
          state      <= ST_IDLE;
          ack_active <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### verification/ciru_checker.sv
`timescale 1ns/1ns
`default_nettype none

module ciru_checker
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic last_cycle_sample,
  input wire logic exec_enable_all,
  input wire logic exec_mask_all,
  input wire logic exec_return_from_nonmaskable,
  input wire logic insn_undefined,
  input wire logic ack_active,
  input wire logic opcode_fetch_strobe_n,
  input wire logic io_request_strobe_n,
  input wire logic wait_state,
  input wire logic insn_valid,
  input wire logic trap_req,
  input wire logic global_mask_flag,
  input wire logic saved_mask_flag
);
  logic [2:0] wait_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Wait states are counted over the whole strobe window, so a one-cycle lag still fits.
  always_ff @(posedge clk)
  begin
    if (!nrst || opcode_fetch_strobe_n)
      wait_cnt <= 3'h0;
    else if (wait_state)
      wait_cnt <= wait_cnt + 3'h1;
  end

  chk_strobe_pair: assert property (opcode_fetch_strobe_n == io_request_strobe_n)
    else $error("fetch strobes differ");
  chk_strobe_len: assert property ($fell(opcode_fetch_strobe_n) |->
    !opcode_fetch_strobe_n[*5] ##1 opcode_fetch_strobe_n)
    else $error("vector fetch is not five cycles long");
  chk_two_waits: assert property ($rose(opcode_fetch_strobe_n) |-> wait_cnt == 3'h2)
    else $error("vector fetch without two wait states");
  chk_strobe_in_ack: assert property (!opcode_fetch_strobe_n |-> ack_active)
    else $error("fetch strobe outside acknowledge");
  chk_ack_masks: assert property ($rose(ack_active) |-> !global_mask_flag)
    else $error("global flag still set in acknowledge");
  chk_return_from_nonmaskable_restore: assert property (exec_return_from_nonmaskable && !last_cycle_sample |=>
    global_mask_flag == $past(saved_mask_flag))
    else $error("return did not restore global flag");
  chk_enable_all: assert property (exec_enable_all && !exec_return_from_nonmaskable && !last_cycle_sample
    |=> global_mask_flag && saved_mask_flag)
    else $error("enable-all left a flag clear");
  chk_mask_all: assert property (exec_mask_all && !exec_enable_all && !exec_return_from_nonmaskable
    && !last_cycle_sample |=> !global_mask_flag && !saved_mask_flag)
    else $error("mask-all left a flag set");
  chk_undef_trap: assert property (insn_valid && insn_undefined |=> trap_req)
    else $error("undefined acknowledge byte gave no trap");
endmodule

bind ciru_top ciru_checker ciru_checker_i
(
  .clk, .nrst, .last_cycle_sample, .exec_enable_all, .exec_mask_all, .exec_return_from_nonmaskable,
  .insn_undefined, .ack_active, .opcode_fetch_strobe_n, .io_request_strobe_n, .wait_state,
  .insn_valid, .trap_req, .global_mask_flag, .saved_mask_flag
);

`default_nettype wire

// ### verification/ciru_partner.sv
`timescale 1ns/1ns
`default_nettype none

module ciru_partner
(
  input  wire logic        clk,
  input  wire logic        opcode_fetch_strobe_n,
  input  wire logic        io_request_strobe_n,
  input  wire logic        vec_read,
  input  wire logic [15:0] vec_addr,
  input  wire logic [7:0]  ack_byte,
  input  wire logic        slow,
  output var  logic [7:0]  data_in,
  output var  logic [7:0]  mem_rdata,
  output var  logic        mem_valid
);
  logic [15:0] addr;
  logic [2:0]  cnt;

  initial
  begin
    {data_in, mem_rdata, mem_valid, cnt, addr} = '0;
  end

  // Bus only while acknowledged.
  // A released bus toggles so that a stale capture cannot pass by luck.
  always @(posedge clk)
  begin
    if (!opcode_fetch_strobe_n && !io_request_strobe_n)
      data_in <= ack_byte;
    else
      data_in <= ~data_in;
  end

  // Table read answer.
  // Each table byte is its own low address plus 11h, answered after one or four cycles.
  always @(posedge clk)
  begin
    mem_valid <= 1'b0;
    if (vec_read)
    begin
      addr <= vec_addr;
      cnt <= slow ? 3'h4 : 3'h1;
    end
    else if (cnt == 3'h1)
    begin
      mem_valid <= 1'b1;
      mem_rdata <= addr[7:0] + 8'h11;
      cnt <= 3'h0;
    end
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule

`default_nettype wire

// ### verification/ciru_top_test.sv
`timescale 1ns/1ns
`default_nettype none

`include "ciru_regs.vh"

module ciru_top_test;
  logic        clk, nrst, reg_wr, reg_rd, nmi_n, level0_request_n, level1_request_n;
  logic        level2_request_n, last_cycle_sample, mcycle_end, exec_enable_all, exec_mask_all;
  logic        exec_return_from_nonmaskable, exec_mode_set, insn_undefined, mem_valid, slow, done, ack_seen;
  logic        ack_active, opcode_fetch_strobe_n, io_request_strobe_n, wait_state, push_pc;
  logic        restart_valid, vec_read, insn_valid, trap_req, global_mask_flag;
  logic        saved_mask_flag, dma_master_enable;
  logic [1:0]  exec_mode;
  logic [6:0]  int_req, int_enable;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, data_in, mem_rdata, ack_byte, insn_byte, ib;
  logic [15:0] restart_addr, vec_addr, rs, va;
  int          error_cnt, checked, pushes, traps, cycles;

  ciru_top ciru_top_i
  (
    .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nmi_n,
    .level0_request_n, .level1_request_n, .level2_request_n, .int_req, .int_enable,
    .last_cycle_sample, .mcycle_end, .exec_enable_all, .exec_mask_all, .exec_return_from_nonmaskable,
    .exec_mode_set, .exec_mode, .data_in, .insn_undefined, .mem_rdata, .mem_valid,
    .ack_active, .opcode_fetch_strobe_n, .io_request_strobe_n, .wait_state, .push_pc,
    .restart_valid, .restart_addr, .vec_read, .vec_addr, .insn_valid, .insn_byte, .trap_req,
    .global_mask_flag, .saved_mask_flag, .dma_master_enable
  );

  ciru_partner ciru_partner_i
  (
    .clk, .opcode_fetch_strobe_n, .io_request_strobe_n, .vec_read, .vec_addr, .ack_byte,
    .slow, .data_in, .mem_rdata, .mem_valid
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    cmp(16'(reg_rdata), 16'(e));
    @(posedge clk);
  endtask

  // Instruction events: 0 enable-all, 1 mask-all, 2 return, 3..5 select mode 0..2.
  task automatic ins(input int k);
    exec_enable_all <= (k == 0);
    exec_mask_all <= (k == 1);
    exec_return_from_nonmaskable <= (k == 2);
    exec_mode_set <= (k > 2);
    exec_mode <= 2'(k - 3);
    @(posedge clk);
    {exec_enable_all, exec_mask_all, exec_return_from_nonmaskable, exec_mode_set} <= 4'h0;
    @(posedge clk);
  endtask

  // One sampling point, then the end of the machine cycle, then wait for completion.
  task automatic take;
    {done, ack_seen, pushes, traps} = '0;
    last_cycle_sample <= 1'b1;
    @(posedge clk);
    last_cycle_sample <= 1'b0;
    mcycle_end <= 1'b1;
    @(posedge clk);
    mcycle_end <= 1'b0;
    for (int i = 0; i < 40 && !done; i++)
      @(posedge clk);
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [15:0] tbl(input logic [15:0] a);
    logic [15:0] b;
    b = a + 16'h1;
    return {b[7:0] + 8'h11, a[7:0] + 8'h11};
  endfunction

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (ack_active) ack_seen <= 1'b1;
    if (push_pc) pushes <= pushes + 1;
    if (trap_req) traps <= traps + 1;
    if (push_pc && vec_read) va <= vec_addr;
    if (insn_valid) ib <= insn_byte;
    if (restart_valid) rs <= restart_addr;
    if (restart_valid || insn_valid) done <= 1'b1;
    if (cycles == 4000)
    begin
      error_cnt++;
      give_verdict;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst, reg_wr, reg_rd, last_cycle_sample, mcycle_end, exec_enable_all} = '0;
    {exec_mask_all, exec_return_from_nonmaskable, exec_mode_set, exec_mode, insn_undefined, slow} = '0;
    {int_req, int_enable, reg_addr, reg_wdata, ack_byte} = '0;
    {nmi_n, level0_request_n, level1_request_n, level2_request_n} = 4'hf;
    {error_cnt, checked, cycles} = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    cmp({global_mask_flag, saved_mask_flag, dma_master_enable, opcode_fetch_strobe_n}, 16'h1);
    rd(`CIRU_OFS_TRAP_CTRL, `CIRU_TC_RESET);
    rd(`CIRU_OFS_VEC_BASE, 8'h00);
    rd(`CIRU_OFS_VEC_LOW, 8'h00);
    rd(8'h20, 8'h00);
    $display("test reset done");

    wr(`CIRU_OFS_DMA_CTRL, 8'h01);
    ins(0);
    cmp({global_mask_flag, saved_mask_flag, dma_master_enable}, 16'h7);
    nmi_n <= 1'b0;
    repeat (2) @(posedge clk);
    nmi_n <= 1'b1;
    @(posedge clk);
    take;
    cmp({global_mask_flag, saved_mask_flag, dma_master_enable}, 16'h2);
    cmp(rs, `CIRU_NMI_ADDR);
    cmp(16'(pushes), 16'h1);
    ins(2);
    cmp(16'(global_mask_flag), 16'h1);
    ins(1);
    cmp({global_mask_flag, saved_mask_flag}, 16'h0);
    $display("test nonmaskable done");

    {level0_request_n, level1_request_n, level2_request_n} <= 3'h0;
    int_req <= 7'h7f;
    int_enable <= 7'h7f;
    wr(`CIRU_OFS_TRAP_CTRL, 8'h07);
    take;
    cmp(16'(ack_seen), 16'h0);
    wr(`CIRU_OFS_TRAP_CTRL, 8'h00);
    int_enable <= 7'h00;
    ins(0);
    take;
    cmp(16'(ack_seen), 16'h0);
    $display("test masking done");

    int_enable <= 7'h7f;
    wr(`CIRU_OFS_TRAP_CTRL, 8'h07);
    ins(4);
    ins(0);
    nmi_n <= 1'b0;
    repeat (3) @(posedge clk);
    take;
    cmp(rs, `CIRU_NMI_ADDR);
    ins(2);
    take;
    cmp(rs, `CIRU_MODE1_ADDR);
    cmp({global_mask_flag, saved_mask_flag, 14'(pushes)}, 16'h1);
    nmi_n <= 1'b1;
    level0_request_n <= 1'b1;
    $display("test priority done");

    wr(`CIRU_OFS_VEC_BASE, 8'h12);
    wr(`CIRU_OFS_VEC_LOW, 8'ha5);
    rd(`CIRU_OFS_VEC_LOW, 8'ha0);
    for (int k = 0; k < 9; k++)
    begin
      level1_request_n <= (k != 0);
      level2_request_n <= (k > 1);
      int_req <= (k < 2) ? 7'h7f : 7'(7'h7f << (k - 2));
      slow <= k[0];
      ins(0);
      take;
      cmp(va, {8'h12, 8'ha0 | 8'(2 * k)});
      cmp(rs, tbl({8'h12, 8'ha0 | 8'(2 * k)}));
      cmp(16'(pushes), 16'h1);
    end
    {level1_request_n, level2_request_n, int_req} <= {2'h3, 7'h00};
    $display("test vectored done");

    ins(5);
    ack_byte <= 8'h34;
    level0_request_n <= 1'b0;
    ins(0);
    take;
    cmp(va, 16'h1234);
    cmp(rs, tbl(16'h1234));
    ins(3);
    ack_byte <= 8'hc7;
    insn_undefined <= 1'b1;
    ins(0);
    take;
    cmp(16'(ib), 16'h00c7);
    cmp({14'(pushes), 2'(traps)}, 16'h1);
    ack_byte <= 8'h00;
    insn_undefined <= 1'b0;
    ins(0);
    take;
    cmp({ib, 8'(traps)}, 16'h0000);
    level0_request_n <= 1'b1;
    rd(`CIRU_OFS_TRAP_CTRL, 8'h87);
    wr(`CIRU_OFS_TRAP_CTRL, 8'h07);
    rd(`CIRU_OFS_TRAP_CTRL, 8'h07);
    $display("test acknowledge done");
    give_verdict;
  end
endmodule

`default_nettype wire
